// File: design/misc_sysctl_pkg.sv
// register offsets, field positions, reset values and carrier types
// for the miscellaneous system control register bank.
// assumes an 8-bit special function register bus inside the core.
package misc_sysctl_pkg;

    // ****************************************************************
    // register offsets
    // ****************************************************************
    localparam logic [7:0] ADDR_TIMER_CLOCK_SELECT = 8'h8E;
    localparam logic [7:0] ADDR_PORT_ONE_LATCH = 8'h90;
    localparam logic [7:0] ADDR_PORT_TWO_LATCH = 8'hA0;
    localparam logic [7:0] ADDR_AUX_FUNCTION_CONTROL = 8'hA2;
    localparam logic [7:0] ADDR_EDGE_DETECT_CONTROL = 8'hA3;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int TIMER_ONE_PRESCALE_SEL_BIT = 4;
    localparam int TIMER_ZERO_PRESCALE_SEL_BIT = 3;
    localparam int EDGE_EVENT_FLAG_BIT = 7;
    localparam int BROWNOUT_OFF_BIT = 6;
    localparam int BROWNOUT_IRQ_MODE_BIT = 5;
    localparam int LOWPOWER_BROWNOUT_BIT = 4;
    localparam int SOFT_CHIP_RESET_BIT = 3;
    localparam int CONVERTER_POWER_ON_BIT = 2;
    localparam int SQUARE_WAVE_ON_BIT = 1;
    localparam int PORT_TWO_WIDTH = 2;
    localparam int EDGE_CHANNELS = 3;

    // ****************************************************************
    // reset values and counts
    // ****************************************************************
    localparam logic [7:0] TIMER_CLOCK_SELECT_RST = 8'h00;
    localparam logic [7:0] AUX_FUNCTION_CONTROL_RST = 8'h00;
    localparam logic [7:0] EDGE_DETECT_CONTROL_RST = 8'h00;
    localparam logic [7:0] PORT_ONE_LATCH_RST = 8'hFF;
    localparam logic [1:0] PORT_TWO_LATCH_RST = 2'h3;
    localparam logic [3:0] PRESCALE_SLOW_DIV = 4'hC;
    localparam logic [3:0] PRESCALE_FAST_DIV = 4'h4;
    localparam logic [2:0] FILTER_DIV_CNT_RST = 3'h0;

    // ****************************************************************
    // carrier types
    // ****************************************************************
    typedef struct packed {
        logic pulseOutputTwo;
        logic comparatorInputPin;
        logic resetInputPin;
        logic extIrqOne;
        logic converterTriggerPin;
        logic extIrqZero;
        logic timerZeroPin;
    } port_one_alt_in_t;

    typedef struct packed {
        logic detectorOn;
        logic lowPower;
        logic keepRcOsc;
        logic chipReset;
        logic irqRequest;
    } brownout_ctl_t;

endpackage : misc_sysctl_pkg

// File: design/edge_input_filter.sv
// glitch filter for the edge inputs, sampled on a divided clock enable.
// assumes the raw inputs are already synchronous to sys_clk.
`timescale 1ns/100ps
`default_nettype none
module edge_input_filter
    import misc_sysctl_pkg::*;
#(
    parameter int CHANNELS = 3
)(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // control
    input wire logic [1:0] filterDiv,
    // levels
    input wire logic [CHANNELS-1:0] rawIn,
    output logic [CHANNELS-1:0] filtered
);

    // ****************************************************************
    // filter clock enable: divide by 1, 2, 4 or 8
    // ****************************************************************
    logic [2:0] divCnt_r;
    logic [2:0] divLimit;
    logic filterTick;

    assign divLimit = 3'((4'h1 << filterDiv) - 4'h1);
    // >= so a smaller code chosen mid-count cannot stall the enable
    assign filterTick = (divCnt_r >= divLimit);

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            divCnt_r <= FILTER_DIV_CNT_RST;
        else if (filterTick)
            divCnt_r <= FILTER_DIV_CNT_RST;
        else
            divCnt_r <= divCnt_r + 3'h1;
    end

    // ****************************************************************
    // per channel: two agreeing samples move the filtered level
    // ****************************************************************
    genvar ch;
    generate
        for (ch = 0; ch < CHANNELS; ch++)
        begin : g_chan
            logic sample_r;
            logic level_r;
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                begin
                    sample_r <= 1'b1;
                    level_r <= 1'b1;
                end
                else if (filterTick)
                begin
                    sample_r <= rawIn[ch];
                    if (rawIn[ch] == sample_r)
                        level_r <= rawIn[ch];
                end
            end
            assign filtered[ch] = level_r;
        end
    endgenerate

    AST_FILTER_DIV8: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (filterTick && filterDiv == 2'h3) ##1 (filterDiv == 2'h3) [*8]
        |-> filterTick && $past(!filterTick))
        else $error("filter enable not one in eight");

endmodule : edge_input_filter
`default_nettype wire

// File: design/misc_system_control_regs.sv
// special function register bank: timer prescale select, two ports,
// auxiliary control and edge-detect control.
// assumes a core bus that presents one access per cycle and a pin pad
// with pull-ups, so a released pin reads high.
//
// Contract
// - timer one ticks every 12 clocks when select clear, every 4 when set
// - ordinary port read returns the pin levels
// - read-modify-write port read returns the output latch
// - all port pins released while power-on reset holds
// - after reset each latch loads from the reset-level strap
// - port one pins carry the listed alternate functions
// - port two has bits 1 and 0 only, upper bits reserved
// - enabled edge on port one pins 0 to 2 sets the edge flag
// - edge flag stays set until software writes it to zero
// - brownout off bit clear enables detector, set switches it off
// - brownout resets chip unless interrupt mode bit set
// - low-power bit selects reduced-power brownout detector running
// - power-down with brownout enabled keeps RC oscillator running
// - writing one to soft reset bit resets the chip
// - converter power bit powers converter when one
// - square-wave enable drives square wave onto port one bit 0
// - edge control holds filter select and per-input trigger, enable
// - filter clock is oscillator over 1, 2, 4 or 8
// - trigger bit zero falling only, one both edges
// - enable bit one makes the pin an edge source
`timescale 1ns/100ps
`default_nettype none
module misc_system_control_regs
    import misc_sysctl_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    // register bus
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic [7:0] sfrWrData,
    input wire logic sfrRdEn,
    input wire logic sfrRmw,
    output logic [7:0] sfrRdData,
    output logic sfrRdHit,
    // configuration strap
    input wire logic resetPortLevelCfg,
    // port one pins
    input wire logic [7:0] portOnePinIn,
    output logic [7:0] portOnePinOut,
    output logic [7:0] portOnePinOe,
    // port two pins
    input wire logic [PORT_TWO_WIDTH-1:0] portTwoPinIn,
    output logic [PORT_TWO_WIDTH-1:0] portTwoPinOut,
    output logic [PORT_TWO_WIDTH-1:0] portTwoPinOe,
    // peripheral alternate outputs
    input wire logic [7:0] periphAltOut,
    input wire logic [7:0] periphAltEn,
    input wire logic squareWaveIn,
    input wire logic clockOutSrc,
    input wire logic clockOutEn,
    // alternate inputs to peripherals
    output port_one_alt_in_t portOneAltIn,
    output logic crystalClockLevel,
    // timer prescale enables
    output logic timerZeroTick,
    output logic timerOneTick,
    // brownout and power
    input wire logic brownoutFlag,
    input wire logic powerDownMode,
    output brownout_ctl_t brownoutCtl,
    output logic converterPowerOn,
    output logic softChipReset
);

    // ****************************************************************
    // register state
    // ****************************************************************
    logic [7:0] timerClockSelect_r;
    logic [7:0] portOneLatch_r;
    logic [PORT_TWO_WIDTH-1:0] portTwoLatch_r;
    logic [7:0] auxFunctionControl_r;
    logic [7:0] edgeDetectControl_r;
    logic edgeEventFlag_r;
    logic edgeEventFlag_nxt;
    logic latchLoaded_r;
    logic [EDGE_CHANNELS-1:0] edgeLevel;
    logic [EDGE_CHANNELS-1:0] edgePrev_r;
    logic [EDGE_CHANNELS-1:0] edgeHitVec;
    logic edgeHit;
    logic [1:0] timerTick;
    logic [1:0] timerSel;
    logic [7:0] portOneValue;
    logic [PORT_TWO_WIDTH-1:0] portTwoValue;
    logic brownoutOff;
    logic brownoutIrqMode;
    logic lowpowerBrownout;
    logic squareWaveOn;
    logic [1:0] edgeFilterDiv;
    logic [EDGE_CHANNELS-1:0] edgeBothEdges;
    logic [EDGE_CHANNELS-1:0] edgeOn;

    logic wrCkSel;
    logic wrPortOne;
    logic wrPortTwo;
    logic wrAux;
    logic wrEdge;

    assign wrCkSel = sfrWrEn && (sfrAddr == ADDR_TIMER_CLOCK_SELECT);
    assign wrPortOne = sfrWrEn && (sfrAddr == ADDR_PORT_ONE_LATCH);
    assign wrPortTwo = sfrWrEn && (sfrAddr == ADDR_PORT_TWO_LATCH);
    assign wrAux = sfrWrEn && (sfrAddr == ADDR_AUX_FUNCTION_CONTROL);
    assign wrEdge = sfrWrEn && (sfrAddr == ADDR_EDGE_DETECT_CONTROL);

    assign brownoutOff = auxFunctionControl_r[BROWNOUT_OFF_BIT];
    assign brownoutIrqMode = auxFunctionControl_r[BROWNOUT_IRQ_MODE_BIT];
    assign lowpowerBrownout = auxFunctionControl_r[LOWPOWER_BROWNOUT_BIT];
    assign squareWaveOn = auxFunctionControl_r[SQUARE_WAVE_ON_BIT];
    assign edgeFilterDiv = edgeDetectControl_r[7:6];
    assign edgeBothEdges = {edgeDetectControl_r[5], edgeDetectControl_r[3],
        edgeDetectControl_r[1]};
    assign edgeOn = {edgeDetectControl_r[4], edgeDetectControl_r[2],
        edgeDetectControl_r[0]};

    // ****************************************************************
    // control registers
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            timerClockSelect_r <= TIMER_CLOCK_SELECT_RST;
        else if (wrCkSel)
            timerClockSelect_r <= sfrWrData & 8'h18;
    end

    // soft reset bit is a strobe, never stored; flag handled apart
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            auxFunctionControl_r <= AUX_FUNCTION_CONTROL_RST;
        else if (wrAux)
            auxFunctionControl_r <= sfrWrData & 8'h76;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            edgeDetectControl_r <= EDGE_DETECT_CONTROL_RST;
        else if (wrEdge)
            edgeDetectControl_r <= sfrWrData;
    end

    // ****************************************************************
    // port latches: strap loaded at the first edge after release
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            latchLoaded_r <= 1'b0;
        else
            latchLoaded_r <= 1'b1;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            portOneLatch_r <= PORT_ONE_LATCH_RST;
            portTwoLatch_r <= PORT_TWO_LATCH_RST;
        end
        else if (!latchLoaded_r)
        begin
            portOneLatch_r <= {8{resetPortLevelCfg}};
            portTwoLatch_r <= {PORT_TWO_WIDTH{resetPortLevelCfg}};
        end
        else
        begin
            if (wrPortOne)
                portOneLatch_r <= sfrWrData;
            if (wrPortTwo)
                portTwoLatch_r <= sfrWrData[PORT_TWO_WIDTH-1:0];
        end
    end

    // ****************************************************************
    // pin drive: latch gates the alternate output, low is driven,
    // high is left to the pull-up so the pin stays readable
    // ****************************************************************
    always_comb
    begin
        portOneValue = portOneLatch_r;
        for (int i = 0; i < 8; i++)
        begin
            if (periphAltEn[i])
                portOneValue[i] = portOneLatch_r[i] & periphAltOut[i];
        end
        if (squareWaveOn)
            portOneValue[0] = portOneLatch_r[0] & squareWaveIn;
        portTwoValue = portTwoLatch_r;
        if (clockOutEn)
            portTwoValue[0] = portTwoLatch_r[0] & clockOutSrc;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            portOnePinOut <= 8'hFF;
            portOnePinOe <= 8'h00;
            portTwoPinOut <= 2'h3;
            portTwoPinOe <= 2'h0;
        end
        else
        begin
            portOnePinOut <= portOneValue;
            portTwoPinOut <= portTwoValue;
            // released until the latch holds its strap value
            portOnePinOe <= latchLoaded_r ? ~portOneValue : 8'h00;
            portTwoPinOe <= latchLoaded_r ? ~portTwoValue : 2'h0;
        end
    end

    // ****************************************************************
    // alternate pin inputs toward the peripherals
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            portOneAltIn <= '1;
            crystalClockLevel <= 1'b0;
        end
        else
        begin
            portOneAltIn.pulseOutputTwo <= portOnePinIn[7];
            portOneAltIn.comparatorInputPin <= portOnePinIn[6];
            portOneAltIn.resetInputPin <= portOnePinIn[5];
            portOneAltIn.extIrqOne <= portOnePinIn[4];
            portOneAltIn.converterTriggerPin <= portOnePinIn[4];
            portOneAltIn.extIrqZero <= portOnePinIn[3];
            portOneAltIn.timerZeroPin <= portOnePinIn[2];
            crystalClockLevel <= portTwoPinIn[1];
        end
    end

    // ****************************************************************
    // register read: pins for plain reads, latch for read-modify-write
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sfrRdData <= 8'h00;
            sfrRdHit <= 1'b0;
        end
        else if (sfrRdEn)
        begin
            sfrRdHit <= 1'b1;
            case (sfrAddr)
                ADDR_TIMER_CLOCK_SELECT: sfrRdData <= timerClockSelect_r;
                ADDR_PORT_ONE_LATCH:
                    sfrRdData <= sfrRmw ? portOneLatch_r
                        : portOnePinIn;
                ADDR_PORT_TWO_LATCH:
                    sfrRdData <= {6'h00, sfrRmw ? portTwoLatch_r
                        : portTwoPinIn};
                ADDR_AUX_FUNCTION_CONTROL:
                    sfrRdData <= auxFunctionControl_r
                        | {edgeEventFlag_r, 7'h00};
                ADDR_EDGE_DETECT_CONTROL: sfrRdData <= edgeDetectControl_r;
                default:
                begin
                    sfrRdData <= 8'h00;
                    sfrRdHit <= 1'b0;
                end
            endcase
        end
        else
            sfrRdHit <= 1'b0;
    end

    // ****************************************************************
    // timer prescalers
    // ****************************************************************
    assign timerSel[0] = timerClockSelect_r[TIMER_ZERO_PRESCALE_SEL_BIT];
    assign timerSel[1] = timerClockSelect_r[TIMER_ONE_PRESCALE_SEL_BIT];

    genvar t;
    generate
        for (t = 0; t < 2; t++)
        begin : g_prescale
            logic [3:0] cnt_r;
            logic [3:0] limit;
            assign limit = timerSel[t] ? PRESCALE_FAST_DIV
                : PRESCALE_SLOW_DIV;
            assign timerTick[t] = (cnt_r >= limit - 4'h1);
            always_ff @(posedge sys_clk or negedge reset_n)
            begin
                if (!reset_n)
                    cnt_r <= 4'h0;
                else if (timerTick[t])
                    cnt_r <= 4'h0;
                else
                    cnt_r <= cnt_r + 4'h1;
            end
        end
    endgenerate

    assign timerZeroTick = timerTick[0];
    assign timerOneTick = timerTick[1];

    // ****************************************************************
    // edge detection
    // ****************************************************************
    edge_input_filter #(
        .CHANNELS(EDGE_CHANNELS)
    ) u_filter (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .filterDiv(edgeFilterDiv),
        .rawIn(portOnePinIn[EDGE_CHANNELS-1:0]),
        .filtered(edgeLevel)
    );

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            edgePrev_r <= '1;
        else
            edgePrev_r <= edgeLevel;
    end

    assign edgeHitVec = edgeOn & ((edgePrev_r & ~edgeLevel)
        | (edgeBothEdges & ~edgePrev_r & edgeLevel));
    assign edgeHit = |edgeHitVec;

    // a new edge wins over a clearing write in the same cycle
    always_comb
    begin
        edgeEventFlag_nxt = edgeEventFlag_r;
        if (wrAux)
            edgeEventFlag_nxt = sfrWrData[EDGE_EVENT_FLAG_BIT];
        if (edgeHit)
            edgeEventFlag_nxt = 1'b1;
    end

    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
            edgeEventFlag_r <= 1'b0;
        else
            edgeEventFlag_r <= edgeEventFlag_nxt;
    end

    // ****************************************************************
    // brownout, converter and soft reset controls
    // ****************************************************************
    always_ff @(posedge sys_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            brownoutCtl <= '0;
            softChipReset <= 1'b0;
            converterPowerOn <= 1'b0;
        end
        else
        begin
            brownoutCtl.detectorOn <= !brownoutOff;
            brownoutCtl.lowPower <= !brownoutOff && lowpowerBrownout;
            brownoutCtl.keepRcOsc <= !brownoutOff && powerDownMode;
            brownoutCtl.chipReset <= !brownoutOff && brownoutFlag
                && !brownoutIrqMode;
            brownoutCtl.irqRequest <= !brownoutOff && brownoutFlag
                && brownoutIrqMode;
            softChipReset <= wrAux && sfrWrData[SOFT_CHIP_RESET_BIT];
            converterPowerOn <= auxFunctionControl_r[CONVERTER_POWER_ON_BIT];
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    AST_T1_SLOW_GAP: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (timerOneTick && !timerSel[1]) ##1 !timerSel[1] [*8]
        ##1 !timerSel[1] [*3] |=> timerOneTick
        && !$past(timerOneTick, 4) && !$past(timerOneTick, 8))
        else $error("timer one slow tick not every twelve");
    AST_T0_FAST: assert property (@(posedge sys_clk) disable iff (!reset_n)
        (timerZeroTick && timerSel[0]) ##1 timerSel[0] [*4]
        |-> timerZeroTick && !$past(timerZeroTick))
        else $error("timer zero fast tick not every four");
    AST_READ_PINS: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sfrRdEn && !sfrRmw && sfrAddr == ADDR_PORT_ONE_LATCH
        |=> sfrRdData == $past(portOnePinIn))
        else $error("port read did not return pins");
    AST_READ_LATCH: assert property (@(posedge sys_clk) disable iff (!reset_n)
        sfrRdEn && sfrRmw && sfrAddr == ADDR_PORT_ONE_LATCH
        |=> sfrRdData == $past(portOneLatch_r))
        else $error("rmw read did not return latch");
    AST_RELEASED: assert property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(latchLoaded_r) |-> portOnePinOe == 8'h00
        && portTwoPinOe == 2'h0)
        else $error("pin driven before latch load");
    AST_STRAP_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        reset_n && !latchLoaded_r
        |=> portOneLatch_r == {8{$past(resetPortLevelCfg)}})
        else $error("latch not loaded from strap");
    AST_EDGE_SET: assert property (@(posedge sys_clk) disable iff (!reset_n)
        edgeHit |=> edgeEventFlag_r ##1 (edgeEventFlag_r || $past(wrAux)))
        else $error("edge did not set flag");
    AST_FLAG_HOLD: assert property (@(posedge sys_clk) disable iff (!reset_n)
        edgeEventFlag_r && !wrAux |=> edgeEventFlag_r)
        else $error("edge flag cleared by hardware");
    AST_BO_RESET: assert property (@(posedge sys_clk) disable iff (!reset_n)
        brownoutFlag && !brownoutOff && !brownoutIrqMode && !wrAux
        |=> brownoutCtl.chipReset && !brownoutCtl.irqRequest)
        else $error("brownout did not request reset");
    AST_SOFT_RESET: assert property (@(posedge sys_clk) disable iff (!reset_n)
        wrAux && sfrWrData[SOFT_CHIP_RESET_BIT]
        |=> softChipReset ##1 (!softChipReset || $past(wrAux)))
        else $error("soft reset pulse wrong");
    AST_SQUARE_WAVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
        squareWaveOn && latchLoaded_r && portOneLatch_r[0]
        |=> portOnePinOut[0] == $past(squareWaveIn))
        else $error("square wave not on pin");

endmodule : misc_system_control_regs
`default_nettype wire

// File: dv/port_pin_model.sv
// pad model for ports one and two: pull-ups, plus external low drivers on port one.
// assumes the device drives low only and releases for high.
`timescale 1ns/100ps
`default_nettype none
module port_pin_model (
    // device side
    input wire logic [7:0] oneOut,
    input wire logic [7:0] oneOe,
    input wire logic [1:0] twoOut,
    input wire logic [1:0] twoOe,
    // outside pull-downs
    input wire logic [7:0] extLow,
    // pad levels
    output logic [7:0] oneLevel,
    output logic [1:0] twoLevel
);
    // released pins float up, never hold the last value
    assign oneLevel = ~((oneOe & ~oneOut) | extLow);
    assign twoLevel = ~(twoOe & ~twoOut);
endmodule : port_pin_model
`default_nettype wire

// File: dv/misc_system_control_regs_bench.sv
// self-checking bench for the system control register bank.
// assumes the pad model supplies pull-ups on every port pin.
`timescale 1ns/100ps
`default_nettype none
module misc_system_control_regs_bench import misc_sysctl_pkg::*;;
    // ****
    // stimulus and monitors
    // ****
    logic sys_clk = 0, reset_n = 0, we = 0, re = 0, rmw = 0, bf = 0;
    logic pd = 0, cfg = 1, sq = 1, t0, t1, cp, soft_chip_reset, sr = 0, h, xc;
    logic [7:0] a = 8'h00, wd = 8'h00, ext = 8'h00, d, p1o, p1e, p1i;
    logic [1:0] p2o, p2e, p2i;
    brownout_ctl_t bo;
    port_one_alt_in_t ai;
    int mismatches = 0, testsRun = 0, n0 = 0, n1 = 0, s0, s1, cyc = 0;
    misc_system_control_regs i_dut (.sys_clk, .reset_n,
        .sfrAddr(a), .sfrWrEn(we), .sfrWrData(wd), .sfrRdEn(re),
        .sfrRmw(rmw), .sfrRdData(d), .sfrRdHit(h), .resetPortLevelCfg(cfg),
        .portOnePinIn(p1i), .portOnePinOut(p1o), .portOnePinOe(p1e),
        .portTwoPinIn(p2i), .portTwoPinOut(p2o), .portTwoPinOe(p2e),
        .periphAltOut(8'hFF), .periphAltEn(8'h00), .squareWaveIn(sq),
        .clockOutSrc(1'b0), .clockOutEn(1'b0), .portOneAltIn(ai),
        .crystalClockLevel(xc), .timerZeroTick(t0), .timerOneTick(t1),
        .brownoutFlag(bf), .powerDownMode(pd), .brownoutCtl(bo),
        .converterPowerOn(cp), .softChipReset(soft_chip_reset));
    port_pin_model i_pads (.oneOut(p1o), .oneOe(p1e), .twoOut(p2o),
        .twoOe(p2e), .extLow(ext), .oneLevel(p1i), .twoLevel(p2i));
    always #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        n0 <= n0 + int'(t0);
        n1 <= n1 + int'(t1);
        if (soft_chip_reset)
            sr <= 1'b1;
        // a hang would otherwise never reach the verdict
        if (cyc == 3000)
        begin
            mismatches++;
            test_done;
        end
    end
    // ****
    // bus tasks
    // ****
    task wr(input logic [7:0] ad, dt);
        @(posedge sys_clk) {a, wd, we} <= {ad, dt, 1'b1};
        @(posedge sys_clk) we <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] ad, input logic m, output logic [7:0] q);
        @(posedge sys_clk) {a, rmw, re} <= {ad, m, 1'b1};
        @(posedge sys_clk) re <= 1'b0;
        #1 q = d;
    endtask : rd
    task tk(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask : tk
    task chk(input string w, input logic [7:0] s, e);
        testsRun++;
        if (s !== e)
        begin
            mismatches++;
            $display("Error %s exp %h seen %h", w, e, s);
        end
    endtask : chk
    task test_done;
        $display("checks %0d mismatches %0d", testsRun, mismatches);
        if (mismatches == 0 && testsRun > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    // ****
    // tests
    // ****
    logic [7:0] v;
    initial
    begin
        tk(16);
        chk("oe in reset", p1e, 8'h00);
        @(posedge sys_clk) reset_n <= 1'b1;
        tk(2);
        rd(8'h90, 1, v); chk("latch", v, 8'hFF);
        @(posedge sys_clk) ext <= 8'h80;
        rd(8'h90, 0, v); chk("pins", v, 8'h7F);
        chk("alt in", {ai, xc}, 8'h7F);
        rd(8'h90, 1, v); chk("rmw", v, 8'hFF);
        @(posedge sys_clk) ext <= 8'h00;
        rd(8'hA0, 0, v); chk("port two", v, 8'h03);
        chk("hit", {7'h00, h}, 8'h01);
        rd(8'h91, 0, v); chk("unmapped", v, 8'h00);
        chk("miss", {7'h00, h}, 8'h00);
        $display("ports done");
        for (int i = 0; i < 2; i++)
        begin
            wr(8'h8E, i ? 8'h08 : 8'h10);
            tk(12);
            {s0, s1} = {n0, n1};
            tk(48);
            chk("t0", 8'(n0 - s0), i ? 8'h0C : 8'h04);
            chk("t1", 8'(n1 - s1), i ? 8'h04 : 8'h0C);
        end
        wr(8'h8E, 8'hFF); rd(8'h8E, 0, v); chk("tsel", v, 8'h18);
        $display("timers done");
        wr(8'hA3, 8'h01);
        @(posedge sys_clk) ext <= 8'h01;
        tk(16); rd(8'hA2, 0, v); chk("fall", v, 8'h80);
        @(posedge sys_clk) ext <= 8'h00;
        tk(16); rd(8'hA2, 0, v); chk("hold", v, 8'h80);
        wr(8'hA2, 8'h00); rd(8'hA2, 0, v); chk("clear", v, 8'h00);
        wr(8'hA3, 8'h08);
        @(posedge sys_clk) ext <= 8'h02;
        tk(16); rd(8'hA2, 0, v); chk("off", v, 8'h00);
        wr(8'hA3, 8'hCC); rd(8'hA3, 0, v); chk("edc", v, 8'hCC);
        @(posedge sys_clk) ext <= 8'h00;
        tk(48); rd(8'hA2, 0, v); chk("rise", v, 8'h80);
        $display("edges done");
        wr(8'hA2, 8'h0C);
        tk(1);
        chk("adc", {7'h00, cp}, 8'h01);
        chk("soft_chip_reset", {7'h00, sr}, 8'h01);
        rd(8'hA2, 0, v); chk("aux", v, 8'h04);
        @(posedge sys_clk) bf <= 1'b1;
        tk(2); chk("bo rst", {3'h0, bo}, 8'h12);
        wr(8'hA2, 8'h24);
        tk(2); chk("bo irq", {3'h0, bo}, 8'h11);
        @(posedge sys_clk) pd <= 1'b1;
        wr(8'hA2, 8'h10);
        tk(2); chk("bo low", {3'h0, bo}, 8'h1E);
        wr(8'hA2, 8'h40);
        tk(2); chk("bo off", {3'h0, bo}, 8'h00);
        chk("adc off", {7'h00, cp}, 8'h00);
        $display("aux done");
        // second reset with the strap low: latch must gate the alt output
        @(posedge sys_clk) {reset_n, cfg, bf, pd} <= 4'h0;
        tk(3); chk("oe in reset 2", p1e, 8'h00);
        @(posedge sys_clk) reset_n <= 1'b1;
        tk(2);
        rd(8'h90, 1, v); chk("strap low", v, 8'h00);
        wr(8'hA2, 8'h02); tk(2);
        chk("alt held", p1i, 8'h00);
        wr(8'h90, 8'hFF); tk(2);
        chk("square hi", p1i, 8'hFF);
        @(posedge sys_clk) sq <= 1'b0;
        tk(3); chk("square lo", p1i, 8'hFE);
        $display("reset done");
        test_done;
    end
endmodule : misc_system_control_regs_bench
`default_nettype wire
